// ==== logic/argc_pkg.sv ====
// constants for the audio receive gain and routing control block
package argc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_VOICE_GAIN = 8'h00;
  localparam logic [7:0] OFS_STEREO_R_GAIN = 8'h04;
  localparam logic [7:0] OFS_STEREO_L_GAIN = 8'h08;
  localparam logic [7:0] OFS_DMIC_GAIN = 8'h0c;
  localparam logic [7:0] OFS_RIGHT_FB_GAIN = 8'h10;
  localparam logic [7:0] OFS_LEFT_FB_GAIN = 8'h14;
  localparam logic [7:0] OFS_MUTE_MIX = 8'h18;
  localparam logic [7:0] OFS_AMP_CTRL = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // gain channel indices, in register order
  localparam int CH_VOICE = 0;
  localparam int CH_STEREO_R = 1;
  localparam int CH_STEREO_L = 2;
  localparam int CH_DMIC = 3;
  localparam int CH_RIGHT_FB = 4;
  localparam int CH_LEFT_FB = 5;
  localparam int NUM_GAINS = 6;
  // gain code layout: code 0 is -57 dB, one dB per code step
  localparam int GAIN_W = 6;
  localparam logic [5:0] GAIN_RESET = 6'h39;
  localparam logic [6:0] GAIN_DB_OFFSET = 7'h03;
  localparam logic [6:0] DB_PER_OCTAVE = 7'h06;
  localparam int GAIN_SHIFT_BASE = 25;
  // mute and mixer select register fields
  localparam int BIT_VOICE_LEFT_MUTE = 0;
  localparam int BIT_STEREO_LEFT_MUTE = 1;
  localparam int BIT_STEREO_RIGHT_MUTE = 2;
  localparam int BIT_LEFT_MIX_STEREO_SEL = 4;
  localparam int BIT_LEFT_MIX_LINE_SEL = 5;
  localparam int BIT_LEFT_MIX_VOICE_SEL = 6;
  localparam int BIT_RIGHT_MIX_STEREO_SEL = 8;
  localparam int BIT_RIGHT_MIX_LINE_SEL = 9;
  localparam int BIT_RIGHT_MIX_VOICE_SEL = 10;
  localparam int MUTE_MIX_W = 11;
  localparam logic [10:0] MUTE_MIX_RESET = 11'h000;
  // amplifier control register fields
  localparam int BIT_EARPIECE_AMP_EN = 0;
  localparam int BIT_EARPIECE_MUTE = 1;
  localparam int BIT_RIGHT_SPEAKER_EN = 2;
  localparam int BIT_LEFT_SPEAKER_EN = 3;
  localparam int BIT_RIGHT_SPEAKER_MUTE = 4;
  localparam int BIT_LEFT_SPEAKER_MUTE = 5;
  localparam int BIT_RIGHT_HEADSET_EN = 6;
  localparam int BIT_LEFT_HEADSET_EN = 7;
  localparam int BIT_RIGHT_HEADSET_MUTE = 8;
  localparam int BIT_LEFT_HEADSET_MUTE = 9;
  localparam int AMP_CTRL_W = 10;
  localparam logic [9:0] AMP_CTRL_RESET = 10'h000;
  // status register fields
  localparam int BIT_STAT_CHARGE_PUMP = 0;
  localparam int BIT_STAT_AMP_ACTIVE = 1;
endpackage

// ==== logic/argc_top.sv ====
// audio receive gain, mute, mixer and output amplifier control with apb registers
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - separate six-bit voice, stereo right, stereo left gains
// - code 0 is -57 dB, 0x39 0 dB, 0x3f +6
// - dmic sidetone scaled by own six-bit gain
// - right and left input feedback gains, six bits
// - voice left, stereo left, stereo right mutes
// - left mixer sums selected sources
// - right mixer sums selected sources
// - earpiece carries left, needs enable, mute silences
// - speakers enabled individually, fed from own mixer
// - speaker outputs muted individually
// - headsets enabled individually, right and left audio
// - headset outputs muted individually
// - charge pump on while any headset enabled
module argc_top #(
  parameter int SAMPLE_W = 16,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  // apb slave
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // receive samples, same clock domain
  input wire logic I_SAMPLE_STB,
  input wire logic signed [SAMPLE_W-1:0] I_VOICE_DAC,
  input wire logic signed [SAMPLE_W-1:0] I_STEREO_RIGHT,
  input wire logic signed [SAMPLE_W-1:0] I_STEREO_LEFT,
  input wire logic signed [SAMPLE_W-1:0] I_DMIC_SIDETONE,
  input wire logic signed [SAMPLE_W-1:0] I_RIGHT_LINE_INPUT,
  input wire logic signed [SAMPLE_W-1:0] I_LEFT_LINE_INPUT,
  // amplifier audio
  output logic signed [SAMPLE_W-1:0] O_EARPIECE,
  output logic signed [SAMPLE_W-1:0] O_RIGHT_SPEAKER,
  output logic signed [SAMPLE_W-1:0] O_LEFT_SPEAKER,
  output logic signed [SAMPLE_W-1:0] O_HEADSET_RIGHT_OUT,
  output logic signed [SAMPLE_W-1:0] O_HEADSET_LEFT_OUT,
  // amplifier power controls
  output logic O_EARPIECE_AMP_EN,
  output logic O_RIGHT_SPEAKER_EN,
  output logic O_LEFT_SPEAKER_EN,
  output logic O_RIGHT_HEADSET_EN,
  output logic O_LEFT_HEADSET_EN,
  output logic O_CHARGE_PUMP_EN
);

  localparam int SUM_W = SAMPLE_W + 2;
  localparam int PROD_W = SAMPLE_W + 18;

  logic rst_meta_b;
  logic rst_b;
  logic [argc_pkg::GAIN_W-1:0] gain [argc_pkg::NUM_GAINS];
  logic [argc_pkg::MUTE_MIX_W-1:0] mute_mix;
  logic [argc_pkg::AMP_CTRL_W-1:0] amp_ctrl;
  logic signed [SAMPLE_W-1:0] sample_in [argc_pkg::NUM_GAINS];
  logic signed [SAMPLE_W-1:0] gained [argc_pkg::NUM_GAINS];
  logic gained_vld;
  logic signed [SAMPLE_W-1:0] mix_left;
  logic signed [SAMPLE_W-1:0] mix_right;
  logic apb_acc;
  logic apb_done;
  logic [31:0] byte_mask;
  logic [31:0] next_rdata;
  logic next_err;

  // 10^(r/20) for r = 0..5 in q1.15, one octave step is taken as 6 dB
  function automatic logic [16:0] gain_mant(input logic [2:0] r);
    unique case (r)
      3'h0: gain_mant = 17'h08000;
      3'h1: gain_mant = 17'h08f9e;
      3'h2: gain_mant = 17'h0a124;
      3'h3: gain_mant = 17'h0b4ce;
      3'h4: gain_mant = 17'h0cadd;
      default: gain_mant = 17'h0e39f;
    endcase
  endfunction

  // clamp a wide signed value into the sample width
  function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [PROD_W-1:0] v);
    logic signed [PROD_W-1:0] hi;
    logic signed [PROD_W-1:0] lo;
    hi = PROD_W'((1 <<< (SAMPLE_W - 1)) - 1);
    lo = -hi - PROD_W'(1);
    if (v > hi) begin
      sat = hi[SAMPLE_W-1:0];
    end else if (v < lo) begin
      sat = lo[SAMPLE_W-1:0];
    end else begin
      sat = v[SAMPLE_W-1:0];
    end
  endfunction

  // db code + 3 split into octaves and leftover dB, then mantissa times shift
  function automatic logic signed [SAMPLE_W-1:0] apply_gain(
    input logic signed [SAMPLE_W-1:0] s,
    input logic [argc_pkg::GAIN_W-1:0] code
  );
    logic [6:0] db3;
    logic [6:0] oct;
    logic [6:0] rem;
    logic signed [PROD_W-1:0] prod;
    db3 = {1'b0, code} + argc_pkg::GAIN_DB_OFFSET;
    oct = db3 / argc_pkg::DB_PER_OCTAVE;
    rem = db3 % argc_pkg::DB_PER_OCTAVE;
    prod = PROD_W'(s) * $signed({1'b0, gain_mant(rem[2:0])});
    apply_gain = sat(prod >>> (argc_pkg::GAIN_SHIFT_BASE - int'(oct)));
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_b <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_b <= rst_meta_b;
    end
  end

  // apb: one wait state, the write lands on the edge that samples pready high
  assign apb_acc = I_PSEL && I_PENABLE;
  assign apb_done = apb_acc && O_PREADY;
  assign byte_mask = {{8{I_PSTRB[3]}}, {8{I_PSTRB[2]}}, {8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};

  // read data mux and unmapped address detect
  always_comb begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    unique case (I_PADDR)
      argc_pkg::OFS_VOICE_GAIN: next_rdata = 32'(gain[argc_pkg::CH_VOICE]);
      argc_pkg::OFS_STEREO_R_GAIN: next_rdata = 32'(gain[argc_pkg::CH_STEREO_R]);
      argc_pkg::OFS_STEREO_L_GAIN: next_rdata = 32'(gain[argc_pkg::CH_STEREO_L]);
      argc_pkg::OFS_DMIC_GAIN: next_rdata = 32'(gain[argc_pkg::CH_DMIC]);
      argc_pkg::OFS_RIGHT_FB_GAIN: next_rdata = 32'(gain[argc_pkg::CH_RIGHT_FB]);
      argc_pkg::OFS_LEFT_FB_GAIN: next_rdata = 32'(gain[argc_pkg::CH_LEFT_FB]);
      argc_pkg::OFS_MUTE_MIX: next_rdata = 32'(mute_mix);
      argc_pkg::OFS_AMP_CTRL: next_rdata = 32'(amp_ctrl);
      argc_pkg::OFS_STATUS: begin
        next_rdata[argc_pkg::BIT_STAT_CHARGE_PUMP] = O_CHARGE_PUMP_EN;
        next_rdata[argc_pkg::BIT_STAT_AMP_ACTIVE] = O_EARPIECE_AMP_EN | O_RIGHT_SPEAKER_EN |
          O_LEFT_SPEAKER_EN | O_RIGHT_HEADSET_EN | O_LEFT_HEADSET_EN;
      end
      default: next_err = 1'b1;
    endcase
  end

  // apb answer flops
  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= apb_acc && !O_PREADY;
      O_PSLVERR <= apb_acc && !O_PREADY && next_err;
      if (apb_acc && !O_PREADY && !I_PWRITE) begin
        O_PRDATA <= next_rdata;
      end
    end
  end

  // six gain registers, all reset to 0 dB
  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < argc_pkg::NUM_GAINS; i++) begin
        gain[i] <= argc_pkg::GAIN_RESET;
      end
    end else if (apb_done && I_PWRITE && I_PSTRB[0]) begin
      for (int i = 0; i < argc_pkg::NUM_GAINS; i++) begin
        if (I_PADDR == ADDR_W'(4 * i)) begin
          gain[i] <= I_PWDATA[argc_pkg::GAIN_W-1:0];
        end
      end
    end
  end

  // mute and mixer select register
  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      mute_mix <= argc_pkg::MUTE_MIX_RESET;
    end else if (apb_done && I_PWRITE && I_PADDR == argc_pkg::OFS_MUTE_MIX) begin
      mute_mix <= (mute_mix & ~byte_mask[argc_pkg::MUTE_MIX_W-1:0]) |
        (I_PWDATA[argc_pkg::MUTE_MIX_W-1:0] & byte_mask[argc_pkg::MUTE_MIX_W-1:0]);
    end
  end

  // amplifier control register
  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      amp_ctrl <= argc_pkg::AMP_CTRL_RESET;
    end else if (apb_done && I_PWRITE && I_PADDR == argc_pkg::OFS_AMP_CTRL) begin
      amp_ctrl <= (amp_ctrl & ~byte_mask[argc_pkg::AMP_CTRL_W-1:0]) |
        (I_PWDATA[argc_pkg::AMP_CTRL_W-1:0] & byte_mask[argc_pkg::AMP_CTRL_W-1:0]);
    end
  end

  // inputs in channel order so one loop covers every gain stage
  assign sample_in[argc_pkg::CH_VOICE] = I_VOICE_DAC;
  assign sample_in[argc_pkg::CH_STEREO_R] = I_STEREO_RIGHT;
  assign sample_in[argc_pkg::CH_STEREO_L] = I_STEREO_LEFT;
  assign sample_in[argc_pkg::CH_DMIC] = I_DMIC_SIDETONE;
  assign sample_in[argc_pkg::CH_RIGHT_FB] = I_RIGHT_LINE_INPUT;
  assign sample_in[argc_pkg::CH_LEFT_FB] = I_LEFT_LINE_INPUT;

  // stage 1: per-channel gain, sampled on the strobe
  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      gained_vld <= 1'b0;
      for (int i = 0; i < argc_pkg::NUM_GAINS; i++) begin
        gained[i] <= '0;
      end
    end else begin
      gained_vld <= I_SAMPLE_STB;
      if (I_SAMPLE_STB) begin
        for (int i = 0; i < argc_pkg::NUM_GAINS; i++) begin
          gained[i] <= apply_gain(sample_in[i], gain[i]);
        end
      end
    end
  end

  // stage 2: mutes and mixers; sidetone rides on the voice path
  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      mix_left <= '0;
      mix_right <= '0;
    end else if (gained_vld) begin
      mix_left <= sat(PROD_W'(
        ((mute_mix[argc_pkg::BIT_LEFT_MIX_STEREO_SEL] &&
          !mute_mix[argc_pkg::BIT_STEREO_LEFT_MUTE]) ? SUM_W'(gained[argc_pkg::CH_STEREO_L]) :
          SUM_W'(0)) +
        (mute_mix[argc_pkg::BIT_LEFT_MIX_LINE_SEL] ? SUM_W'(gained[argc_pkg::CH_LEFT_FB]) :
          SUM_W'(0)) +
        ((mute_mix[argc_pkg::BIT_LEFT_MIX_VOICE_SEL] &&
          !mute_mix[argc_pkg::BIT_VOICE_LEFT_MUTE]) ?
          SUM_W'(gained[argc_pkg::CH_VOICE]) + SUM_W'(gained[argc_pkg::CH_DMIC]) :
          SUM_W'(0))));
      mix_right <= sat(PROD_W'(
        ((mute_mix[argc_pkg::BIT_RIGHT_MIX_STEREO_SEL] &&
          !mute_mix[argc_pkg::BIT_STEREO_RIGHT_MUTE]) ? SUM_W'(gained[argc_pkg::CH_STEREO_R]) :
          SUM_W'(0)) +
        (mute_mix[argc_pkg::BIT_RIGHT_MIX_LINE_SEL] ? SUM_W'(gained[argc_pkg::CH_RIGHT_FB]) :
          SUM_W'(0)) +
        (mute_mix[argc_pkg::BIT_RIGHT_MIX_VOICE_SEL] ?
          SUM_W'(gained[argc_pkg::CH_VOICE]) + SUM_W'(gained[argc_pkg::CH_DMIC]) :
          SUM_W'(0))));
    end
  end

  // stage 3: amplifier feeds, refreshed every clock so a mute acts at once
  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      O_EARPIECE <= '0;
      O_RIGHT_SPEAKER <= '0;
      O_LEFT_SPEAKER <= '0;
      O_HEADSET_RIGHT_OUT <= '0;
      O_HEADSET_LEFT_OUT <= '0;
    end else begin
      O_EARPIECE <= (amp_ctrl[argc_pkg::BIT_EARPIECE_AMP_EN] &&
        !amp_ctrl[argc_pkg::BIT_EARPIECE_MUTE]) ? mix_left : '0;
      O_RIGHT_SPEAKER <= (amp_ctrl[argc_pkg::BIT_RIGHT_SPEAKER_EN] &&
        !amp_ctrl[argc_pkg::BIT_RIGHT_SPEAKER_MUTE]) ? mix_right : '0;
      O_LEFT_SPEAKER <= (amp_ctrl[argc_pkg::BIT_LEFT_SPEAKER_EN] &&
        !amp_ctrl[argc_pkg::BIT_LEFT_SPEAKER_MUTE]) ? mix_left : '0;
      O_HEADSET_RIGHT_OUT <= (amp_ctrl[argc_pkg::BIT_RIGHT_HEADSET_EN] &&
        !amp_ctrl[argc_pkg::BIT_RIGHT_HEADSET_MUTE]) ? mix_right : '0;
      O_HEADSET_LEFT_OUT <= (amp_ctrl[argc_pkg::BIT_LEFT_HEADSET_EN] &&
        !amp_ctrl[argc_pkg::BIT_LEFT_HEADSET_MUTE]) ? mix_left : '0;
    end
  end

  // amplifier power controls; the pump rises on the same edge as the headset amps, no extra delay
  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      O_EARPIECE_AMP_EN <= 1'b0;
      O_RIGHT_SPEAKER_EN <= 1'b0;
      O_LEFT_SPEAKER_EN <= 1'b0;
      O_RIGHT_HEADSET_EN <= 1'b0;
      O_LEFT_HEADSET_EN <= 1'b0;
      O_CHARGE_PUMP_EN <= 1'b0;
    end else begin
      O_EARPIECE_AMP_EN <= amp_ctrl[argc_pkg::BIT_EARPIECE_AMP_EN];
      O_RIGHT_SPEAKER_EN <= amp_ctrl[argc_pkg::BIT_RIGHT_SPEAKER_EN];
      O_LEFT_SPEAKER_EN <= amp_ctrl[argc_pkg::BIT_LEFT_SPEAKER_EN];
      O_RIGHT_HEADSET_EN <= amp_ctrl[argc_pkg::BIT_RIGHT_HEADSET_EN];
      O_LEFT_HEADSET_EN <= amp_ctrl[argc_pkg::BIT_LEFT_HEADSET_EN];
      O_CHARGE_PUMP_EN <= amp_ctrl[argc_pkg::BIT_RIGHT_HEADSET_EN] |
        amp_ctrl[argc_pkg::BIT_LEFT_HEADSET_EN];
    end
  end

  // checks, all on the system clock
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!rst_b);

  // only the stereo left source, unmuted, at the reset gain
  sequence s_left_unity;
    I_SAMPLE_STB && gain[argc_pkg::CH_STEREO_L] == argc_pkg::GAIN_RESET &&
      mute_mix[argc_pkg::BIT_LEFT_MIX_STEREO_SEL] && !mute_mix[argc_pkg::BIT_STEREO_LEFT_MUTE] &&
      !mute_mix[argc_pkg::BIT_LEFT_MIX_LINE_SEL] && !mute_mix[argc_pkg::BIT_LEFT_MIX_VOICE_SEL];
  endsequence
  sequence s_mix_settled;
    gained_vld ##0 $stable(mute_mix);
  endsequence

  AST_UNITY_GAIN: assert property (s_left_unity ##1 s_mix_settled |=>
    mix_left == $past(I_STEREO_LEFT, 2)) else $error("0 dB code did not pass sample unchanged");
  AST_MIN_GAIN: assert property (I_SAMPLE_STB && gain[argc_pkg::CH_VOICE] == 6'h00 |=>
    gained[argc_pkg::CH_VOICE] <= 46 && gained[argc_pkg::CH_VOICE] >= -46)
    else $error("lowest gain code not near -57 dB");
  AST_STEP_UP: assert property (I_SAMPLE_STB && I_STEREO_RIGHT == 16'h0400 &&
    gain[argc_pkg::CH_STEREO_R] == 6'h3a |=> gained[argc_pkg::CH_STEREO_R] == 16'h047c)
    else $error("one code step above 0 dB not +1 dB");
  AST_LEFT_NO_SRC: assert property (gained_vld && mute_mix[6:4] == 3'h0 |=>
    mix_left == '0) else $error("left mixer not silent with no source");
  AST_RIGHT_MUTED: assert property (gained_vld && !mute_mix[argc_pkg::BIT_RIGHT_MIX_LINE_SEL] &&
    !mute_mix[argc_pkg::BIT_RIGHT_MIX_VOICE_SEL] && mute_mix[argc_pkg::BIT_STEREO_RIGHT_MUTE]
    |=> mix_right == '0) else $error("stereo right mute leaked");
  AST_EARPIECE_OFF: assert property (!amp_ctrl[argc_pkg::BIT_EARPIECE_AMP_EN] ||
    amp_ctrl[argc_pkg::BIT_EARPIECE_MUTE] |=> O_EARPIECE == '0)
    else $error("earpiece driven while off or muted");
  AST_SPEAKER_FEED: assert property (amp_ctrl[argc_pkg::BIT_LEFT_SPEAKER_EN] &&
    !amp_ctrl[argc_pkg::BIT_LEFT_SPEAKER_MUTE] |=> O_LEFT_SPEAKER == $past(mix_left))
    else $error("left speaker not fed from left mixer");
  AST_SPEAKER_MUTE: assert property (amp_ctrl[argc_pkg::BIT_RIGHT_SPEAKER_MUTE] |=>
    O_RIGHT_SPEAKER == '0) else $error("right speaker not muted");
  AST_HEADSET_FEED: assert property (amp_ctrl[argc_pkg::BIT_RIGHT_HEADSET_EN] &&
    !amp_ctrl[argc_pkg::BIT_RIGHT_HEADSET_MUTE] |=> O_HEADSET_RIGHT_OUT == $past(mix_right))
    else $error("right headset not fed from right mixer");
  AST_HEADSET_MUTE: assert property (amp_ctrl[argc_pkg::BIT_LEFT_HEADSET_MUTE] |=>
    O_HEADSET_LEFT_OUT == '0) else $error("left headset not muted");
  AST_PUMP: assert property (O_CHARGE_PUMP_EN == (O_RIGHT_HEADSET_EN || O_LEFT_HEADSET_EN))
    else $error("charge pump does not follow headset enables");
  AST_GAIN_WRITE: assert property (apb_done && I_PWRITE && I_PSTRB[0] &&
    I_PADDR == argc_pkg::OFS_VOICE_GAIN |=> gain[argc_pkg::CH_VOICE] == $past(I_PWDATA[5:0]))
    else $error("voice gain write lost");

endmodule

`default_nettype wire

// ==== test/test_argc_top.sv ====
// self-checking testbench for the audio receive gain and routing control block
`timescale 1ns/1ps
`default_nettype none
module test_argc_top;
  typedef struct packed {logic [15:0] ear, rs, ls, hr, hl; logic [5:0] en;} argc_exp_t;
  typedef struct packed {logic [31:0] data; logic err; logic rd;} argc_bus_t;
  logic clk, rst_b, psel, penable, pwrite, stb, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [3:0] sh = 4'h0;
  logic signed [15:0] smp [6];
  logic signed [15:0] ear, rspk, lspk, hr, hl;
  logic ear_en, rs_en, ls_en, rh_en, lh_en, cp_en;
  logic [31:0] regs [8];
  logic [5:0] tbl [5] = '{6'h00, 6'h01, 6'h39, 6'h3e, 6'h3f};
  argc_exp_t exp_q [$];
  argc_bus_t bus_q [$];
  argc_exp_t me;
  argc_bus_t mb;
  int err_total, n_tests;

  argc_top dut_u (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_PADDR(paddr), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SAMPLE_STB(stb), .I_VOICE_DAC(smp[0]),
    .I_STEREO_RIGHT(smp[1]), .I_STEREO_LEFT(smp[2]), .I_DMIC_SIDETONE(smp[3]),
    .I_RIGHT_LINE_INPUT(smp[4]), .I_LEFT_LINE_INPUT(smp[5]), .O_EARPIECE(ear),
    .O_RIGHT_SPEAKER(rspk), .O_LEFT_SPEAKER(lspk), .O_HEADSET_RIGHT_OUT(hr),
    .O_HEADSET_LEFT_OUT(hl), .O_EARPIECE_AMP_EN(ear_en), .O_RIGHT_SPEAKER_EN(rs_en),
    .O_LEFT_SPEAKER_EN(ls_en), .O_RIGHT_HEADSET_EN(rh_en), .O_LEFT_HEADSET_EN(lh_en),
    .O_CHARGE_PUMP_EN(cp_en)
  );

  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // reference gain: mantissa times power of two, floored then saturated
  function automatic logic [15:0] gain(input logic signed [15:0] s, input logic [5:0] c);
    int q;
    logic [15:0] m;
    longint p;
    q = (int'(c) + 3) / 6;
    case ((int'(c) + 3) % 6)
      0: m = 16'h8000;
      1: m = 16'h8f9e;
      2: m = 16'ha124;
      3: m = 16'hb4ce;
      4: m = 16'hcadd;
      default: m = 16'he39f;
    endcase
    p = (longint'(s) * longint'(m)) >>> (25 - q);
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction

  function automatic logic [31:0] rd_exp(input logic [7:0] a);
    logic [31:0] ac;
    ac = regs[7];
    if (a < 8'h20) return regs[a[4:2]];
    if (a == 8'h20) return {30'h0, |{ac[0], ac[2], ac[3], ac[6], ac[7]}, ac[6] | ac[7]};
    return 32'h0;
  endfunction

  // one apb transfer; the expectation is queued before the request goes out
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] st);
    argc_bus_t b;
    int n;
    logic [31:0] m;
    b.rd = !w;
    b.err = (a > 8'h20);
    b.data = rd_exp(a);
    bus_q.push_back(b);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    if (w && a < 8'h18 && st[0]) regs[a[4:2]] = d & 32'h3f;
    if (w && a == 8'h18) regs[6] = ((regs[6] & ~m) | (d & m)) & 32'h7ff;
    if (w && a == 8'h1c) regs[7] = ((regs[7] & ~m) | (d & m)) & 32'h3ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // works out the five amplifier outputs for the samples now on the inputs
  task automatic push_samples();
    logic [15:0] g [6];
    int ml, mr;
    logic [31:0] mm, ac;
    argc_exp_t e;
    for (int k = 0; k < 6; k++) g[k] = gain(smp[k], regs[k][5:0]);
    mm = regs[6];
    ac = regs[7];
    ml = 0;
    mr = 0;
    if (mm[4] && !mm[1]) ml += int'($signed(g[2]));
    if (mm[5]) ml += int'($signed(g[5]));
    if (mm[6] && !mm[0]) ml += int'($signed(g[0])) + int'($signed(g[3]));
    if (mm[8] && !mm[2]) mr += int'($signed(g[1]));
    if (mm[9]) mr += int'($signed(g[4]));
    if (mm[10]) mr += int'($signed(g[0])) + int'($signed(g[3]));
    e.ear = (ac[0] && !ac[1]) ? ml[15:0] : 16'h0000;
    e.rs = (ac[2] && !ac[4]) ? mr[15:0] : 16'h0000;
    e.ls = (ac[3] && !ac[5]) ? ml[15:0] : 16'h0000;
    e.hr = (ac[6] && !ac[8]) ? mr[15:0] : 16'h0000;
    e.hl = (ac[7] && !ac[9]) ? ml[15:0] : 16'h0000;
    e.en = {ac[0], ac[2], ac[3], ac[6], ac[7], ac[6] | ac[7]};
    exp_q.push_back(e);
  endtask

  // bus monitor: every completed transfer takes the oldest bus note
  always @(posedge clk) begin
    if (pready === 1'b1 && psel === 1'b1 && penable === 1'b1) begin
      if (bus_q.size() == 0) check(32'h1, 32'h0);
      else begin
        mb = bus_q.pop_front();
        check(32'(pslverr), 32'(mb.err));
        if (mb.rd) check(prdata, mb.data);
      end
    end
  end

  // audio monitor: outputs land two edges after the strobe edge and are checked on the third
  always @(posedge clk) sh <= {sh[2:0], stb};
  always @(posedge clk) begin
    #1;
    // an output window with no note behind it is a fault of its own
    if (sh[3] === 1'b1 && exp_q.size() == 0) check(32'h1, 32'h0);
    if (sh[3] === 1'b1 && exp_q.size() > 0) begin
      me = exp_q.pop_front();
      check(32'($unsigned(ear)), 32'(me.ear));
      check(32'($unsigned(rspk)), 32'(me.rs));
      check(32'($unsigned(lspk)), 32'(me.ls));
      check(32'($unsigned(hr)), 32'(me.hr));
      check(32'($unsigned(hl)), 32'(me.hl));
      check(32'({ear_en, rs_en, ls_en, rh_en, lh_en, cp_en}), 32'(me.en));
    end
  end

  // watchdog sized well above the roughly 2100 cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    void'($urandom(32'h9d6c2834));
    {rst_b, psel, penable, pwrite, stb, paddr, pwdata, pstrb} = '0;
    for (int k = 0; k < 6; k++) smp[k] = 16'h0000;
    for (int k = 0; k < 8; k++) regs[k] = (k < 6) ? 32'h39 : 32'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // the internal copy of reset is still low here, so every output must be quiet
    #1;
    check(32'($unsigned(ear | rspk | lspk | hr | hl)), 32'h0);
    check(32'({ear_en, rs_en, ls_en, rh_en, lh_en, cp_en, pready, pslverr}), 32'h0);
    repeat (3) @(posedge clk);
    // reset values, then refused and ignored writes
    for (int a = 0; a <= 8'h24; a += 4) apb(8'(a), 1'b0, 32'h0, 4'hf);
    apb(8'h40, 1'b1, $urandom, 4'hf);
    apb(8'h20, 1'b1, 32'hffffffff, 4'hf);
    // one code above 0 dB on stereo right beside 0 dB stereo left, speakers only
    apb(8'h04, 1'b1, 32'h3a, 4'hf);
    apb(8'h18, 1'b1, 32'h110, 4'hf);
    apb(8'h1c, 1'b1, 32'h00c, 4'hf);
    @(posedge clk);
    stb <= 1'b1;
    for (int k = 0; k < 6; k++) smp[k] <= 16'h0400;
    @(posedge clk);
    stb <= 1'b0;
    push_samples();
    repeat (5) @(posedge clk);
    for (int i = 0; i < 40; i++) begin
      // first passes walk the gain endpoints with every path open
      for (int k = 0; k < 6; k++) begin
        apb(8'(k * 4), 1'b1, (i < 5) ? 32'(tbl[i]) : $urandom, (i < 5) ? 4'hf : 4'($urandom));
      end
      apb(8'h18, 1'b1, (i < 5) ? 32'h770 : $urandom, (i < 5) ? 4'hf : 4'($urandom));
      apb(8'h1c, 1'b1, (i < 5) ? 32'h0cd : $urandom, (i < 5) ? 4'hf : 4'($urandom));
      apb(8'h18, 1'b0, 32'h0, 4'hf);
      apb(8'h1c, 1'b0, 32'h0, 4'hf);
      apb(8'h20, 1'b0, 32'h0, 4'hf);
      @(posedge clk);
      stb <= 1'b1;
      for (int k = 0; k < 6; k++) smp[k] <= 16'(int'($urandom_range(8000)) - 4000);
      @(posedge clk);
      stb <= 1'b0;
      push_samples();
      // scramble the inputs so a late capture shows up
      for (int k = 0; k < 6; k++) smp[k] <= ~smp[k];
      repeat (5) @(posedge clk);
    end
    close_out();
  end
endmodule
`default_nettype wire
